// ==== rtl/fblp_consts.svh ====
`ifndef FBLP_CONSTS_SVH
`define FBLP_CONSTS_SVH
// Fuse byte reset (erased-part default) values, 0 = programmed
`define FBLP_EXT_DEFAULT   8'hF9
`define FBLP_HIGH_DEFAULT  8'hDF
`define FBLP_LOW_DEFAULT   8'h62
`define FBLP_LOCK_DEFAULT  8'hFF
// Extended byte fields
`define FBLP_EXT_USED_MASK 8'h07
`define FBLP_EXT_RSTVEC    0
`define FBLP_EXT_BSZ_LO    1
`define FBLP_EXT_BSZ_HI    2
// High byte fields
`define FBLP_HI_RSTDIS     7
`define FBLP_HI_DBGLINK    6
`define FBLP_HI_SERPROG    5
`define FBLP_HI_WDON       4
`define FBLP_HI_EEPRES     3
// Low byte fields
`define FBLP_LO_CLOCK_DIVIDE_BY_EIGHT     7
`define FBLP_LO_CLOCK_OUTPUT_ENABLE      6
// Lock byte fields
`define FBLP_LK_MEM_FIRST  0
`define FBLP_LK_MEM_SECOND 1
`define FBLP_LK_APP_A      2
`define FBLP_LK_APP_B      3
`define FBLP_LK_BOOT_A     4
`define FBLP_LK_BOOT_B     5
// Program memory geometry (words)
`define FBLP_ADDR_W        13
`define FBLP_MEM_WORDS     14'h2000
`define FBLP_BOOT_MIN      14'h0080
`endif

// ==== rtl/fblp_pkg.sv ====
package fblp_pkg;
   // Fuse byte selector for programming-side access
   typedef enum logic [1:0] {
      FBLP_SEL_LOW  = 2'h0,
      FBLP_SEL_HIGH = 2'h1,
      FBLP_SEL_EXT  = 2'h2,
      FBLP_SEL_LOCK = 2'h3
   } fblp_sel_e;
   // Lock mode pair, {bit_b, bit_a}
   typedef logic [1:0] fblp_mode_t;
   // Programming-mode tracker states
   typedef enum logic [1:0] {
      FBLP_ST_POWERUP = 2'b00,
      FBLP_ST_NORMAL  = 2'b01,
      FBLP_ST_PROG    = 2'b11
   } fblp_state_e;
endpackage

// ==== rtl/fblp_section_classify.sv ====
`timescale 1ns/1ps
`include "fblp_consts.svh"
// Decides whether a word address lies in the boot loader section
module fblp_section_classify #(
   parameter int ADDR_W = `FBLP_ADDR_W
) (
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [1:0]        bootSize,
   output logic                   inBoot
);
   import fblp_pkg::*;
   localparam logic [ADDR_W:0] MEM_WORDS = (ADDR_W+1)'(`FBLP_MEM_WORDS);
   localparam logic [ADDR_W:0] BOOT_MIN  = (ADDR_W+1)'(`FBLP_BOOT_MIN);
   logic [ADDR_W:0] bootWords;   // Boot section size in words
   logic [ADDR_W:0] boundary;    // First boot word address

   // Size doubles for each step the size code drops (11 smallest)
   always_comb begin
      bootWords = BOOT_MIN << (2'h3 - bootSize);
      boundary  = MEM_WORDS - bootWords;
      inBoot    = ({1'b0, addr} >= boundary);
   end
endmodule

// ==== rtl/fblp_lock_check.sv ====
`timescale 1ns/1ps
`include "fblp_consts.svh"
// Judges one access against the application and boot lock pairs
module fblp_lock_check (
   input  wire logic                 execInBoot,
   input  wire logic                 targetInBoot,
   input  wire logic                 isWrite,
   input  wire fblp_pkg::fblp_mode_t appMode,
   input  wire fblp_pkg::fblp_mode_t bootMode,
   output logic                      allow
);
   import fblp_pkg::*;
   fblp_mode_t mode;     // Lock pair for target section
   logic       crossRead; // Read from the other section

   // Pick lock pair and apply its table
   always_comb begin
      mode      = targetInBoot ? bootMode : appMode;
      crossRead = (execInBoot != targetInBoot);
      allow     = 1'b1;
      if (isWrite) begin
         allow = mode[0];            // see (R2) (R3) (R7) (R8)
      end else if (crossRead) begin
         allow = mode[1];            // see (R3) (R4) (R8) (R9)
      end
      if (mode == 2'b11) begin
         allow = 1'b1;               // see (R1) (R6)
      end
   end
endmodule

// ==== rtl/fblp_protect.sv ====
`timescale 1ns/1ps
`include "fblp_consts.svh"
// Functional notes
// (R1) App locks 11: app access unrestricted
// (R2) App locks 10: block writes to app
// (R3) App locks 00: block app writes, boot reads
// (R4) App locks 01: block boot-code reads of app
// (R5) App locks 0x: mask irq in app
// (R6) Boot locks 11: boot access unrestricted
// (R7) Boot locks 10: block writes to boot
// (R8) Boot locks 00: block writes, app reads
// (R9) Boot locks 01: block app-code reads of boot
// (R10) Boot locks 0x: mask irq in boot
// (R11) Programmed fuse reads zero
// (R12) Extended byte: size 2:1, vector 0
// (R13) High byte field placement and defaults
// (R14) Serial path cannot change serial enable
// (R15) Low byte fields, default internal RC
// (R16) Clock-output fuse drives port B bit zero
// (R17) Chip erase keeps fuses
// (R18) First memory lock freezes fuses
// (R19) Programmer sets fuses before memory locks
// (R20) Fuses latched entering programming mode
// (R21) EEPROM preserve acts immediately
// (R22) Fuses latched at power-up
// (R23) Only chip erase unprograms lock bits
// (R24) Classify sections by latched boot size
module fblp_protect #(
   parameter int ADDR_W = `FBLP_ADDR_W
) (
   input  wire logic                clock,
   input  wire logic                arst_n,
   // Processor core access request
   input  wire logic [ADDR_W-1:0]   execAddr,
   input  wire logic [ADDR_W-1:0]   targetAddr,
   input  wire logic                storeReq,
   input  wire logic                loadReq,
   output logic                     accessAllow,
   output logic                     accessDeny,
   input  wire logic                irqVectorsInBoot,
   output logic                     irqMask,
   // Programming side fuse and lock port
   input  wire logic                progMode,
   input  wire logic                serialPath,
   input  wire logic                fuseWrite,
   input  wire fblp_pkg::fblp_sel_e fuseSel,
   input  wire logic [7:0]          fuseWdata,
   input  wire logic                chipErase,
   output logic [7:0]               fuseRdata,
   output logic                     writeRefused,
   // Active configuration
   output logic [7:0]               activeExt,
   output logic [7:0]               activeHigh,
   output logic [7:0]               activeLow,
   output logic                     eepromPreserve,
   output logic                     bootResetVector,
   input  wire logic                sysClockIn,
   output logic                     portBBitZeroClk,
   output logic                     portBBitZeroOe
);
   import fblp_pkg::*;

   // Elaboration guard: the section map is fixed to this width
   if (ADDR_W != `FBLP_ADDR_W) begin : gBadWidth
      $error("ADDR_W must match memory geometry");
   end

   // Stored copies, changed only from the programming side
   logic [7:0]  extFuse_ff;    // Nonvolatile extended fuse byte
   logic [7:0]  highFuse_ff;   // Nonvolatile high fuse byte
   logic [7:0]  lowFuse_ff;    // Nonvolatile low fuse byte
   logic [7:0]  lock_ff;       // Nonvolatile lock byte
   // Active copies, refreshed only by the tracker
   logic [7:0]  extAct_ff;     // Latched extended byte
   logic [7:0]  highAct_ff;    // Latched high byte
   logic [7:0]  lowAct_ff;     // Latched low byte
   // Programming level filter and tracker
   logic        progMeta_ff;   // Sync stage one
   logic        progSyncA_ff;  // Sync stage two
   logic        progSyncB_ff;  // Sync stage three
   logic        progLvl_ff;    // Filtered programming level
   fblp_state_e state_ff;      // Latching tracker
   fblp_state_e nxt_state;     // Next tracker state
   logic        latchNow;      // Capture pulse
   logic        fuseLocked;    // Fuse writes frozen
   // Core access path
   logic        execInBoot;    // Executing address section
   logic        targetInBoot;  // Target address section
   logic        anyReq;        // A request is present
   logic        allowRaw;      // Lock check verdict
   logic [7:0]  highWrite;     // High byte after path filter
   fblp_mode_t  appMode;       // Application lock pair
   fblp_mode_t  bootMode;      // Boot lock pair

   // Three stage synchroniser for programming entry
   // Level comes from outside this clock domain
   // First stage may go metastable; only stages two
   // and three feed the rest of the chain
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         progMeta_ff  <= 1'b0;
         progSyncA_ff <= 1'b0;
         progSyncB_ff <= 1'b0;
      end else begin
         progMeta_ff  <= progMode;
         progSyncA_ff <= progMeta_ff;
         progSyncB_ff <= progSyncA_ff;
      end
   end

   // Level changes once last two stages agree
   // A glitch seen by one stage only is ignored
   // Adds one edge of latency to the sync chain
   // Everything downstream reads only this level
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         progLvl_ff <= 1'b0;
      end else if (progSyncA_ff == progSyncB_ff) begin
         progLvl_ff <= progSyncB_ff;
      end
   end

   // Tracker next state
   // Decides when the active copies are refreshed
   // Power-up, entry to and exit from programming
   // Outside those moments stored changes stay hidden
   always_comb begin
      nxt_state = state_ff;
      latchNow  = 1'b0;
      case (state_ff)
         // First edge after reset takes power-up copy
         FBLP_ST_POWERUP: begin
            nxt_state = FBLP_ST_NORMAL;
            latchNow  = 1'b1;                     // see (R22)
         end
         // Normal run, wait for programming entry
         FBLP_ST_NORMAL: begin
            if (progLvl_ff) begin
               nxt_state = FBLP_ST_PROG;
               latchNow  = 1'b1;                  // see (R20)
            end
         end
         // Relatch on exit so new fuses take hold
         FBLP_ST_PROG: begin
            if (!progLvl_ff) begin
               nxt_state = FBLP_ST_NORMAL;
               latchNow  = 1'b1;
            end
         end
         // Unused code recovers through a fresh latch
         default: begin
            nxt_state = FBLP_ST_POWERUP;
         end
      endcase
   end

   // Tracker register
   // Reset parks it in power-up, so the first
   // edge after release latches the stored bytes
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= FBLP_ST_POWERUP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Fuses frozen by first memory lock bit
   // Lock byte itself stays writable so the
   // remaining lock bits can still be programmed
   assign fuseLocked = !lock_ff[`FBLP_LK_MEM_FIRST];   // see (R18)

   // Serial path keeps serial enable bit as stored
   // Stops the serial link from locking itself out
   // Other high byte bits pass through unchanged
   // Only the other programming path may alter it
   always_comb begin
      highWrite = fuseWdata;
      if (serialPath) begin
         highWrite[`FBLP_HI_SERPROG] =
            highFuse_ff[`FBLP_HI_SERPROG];         // see (R14)
      end
   end

   // Fuse store; chip erase never touches it
   // Writes need the filtered programming level
   // A frozen store drops the write; the refusal
   // flag below reports it one edge later
   // Only the addressed byte changes
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         extFuse_ff  <= `FBLP_EXT_DEFAULT;         // see (R12)
         highFuse_ff <= `FBLP_HIGH_DEFAULT;        // see (R13)
         lowFuse_ff  <= `FBLP_LOW_DEFAULT;         // see (R15)
      end else if (fuseWrite && progLvl_ff && !fuseLocked) begin
         case (fuseSel)                            // see (R17)
            // Unused extended bits always stay one
            FBLP_SEL_EXT: begin
               extFuse_ff <= fuseWdata | ~`FBLP_EXT_USED_MASK;
            end
            // High byte after serial path filter
            FBLP_SEL_HIGH: begin
               highFuse_ff <= highWrite;
            end
            // Low byte taken as written
            FBLP_SEL_LOW: begin
               lowFuse_ff <= fuseWdata;
            end
            // Lock byte has its own process
            default: begin
               lowFuse_ff <= lowFuse_ff;
            end
         endcase
      end
   end

   // Lock byte: program only clears, erase restores
   // AND write means a programmed bit never returns
   // to one except through the chip erase strobe
   // Erase wins over a write in the same cycle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_ff <= `FBLP_LOCK_DEFAULT;
      end else if (chipErase && progLvl_ff) begin
         lock_ff <= `FBLP_LOCK_DEFAULT;            // see (R23)
      end else if (fuseWrite && progLvl_ff &&
                   fuseSel == FBLP_SEL_LOCK) begin
         lock_ff <= lock_ff & fuseWdata;           // see (R23)
      end
   end

   // Latched active copy
   // This is the configuration the part runs on
   // Stored bytes reach it only on a tracker pulse
   // Reset value equals the erased-part defaults
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         extAct_ff  <= `FBLP_EXT_DEFAULT;
         highAct_ff <= `FBLP_HIGH_DEFAULT;
         lowAct_ff  <= `FBLP_LOW_DEFAULT;
      end else if (latchNow) begin
         extAct_ff  <= extFuse_ff;                 // see (R20) (R22)
         highAct_ff <= highFuse_ff;
         lowAct_ff  <= lowFuse_ff;
      end
   end

   // Refusal flag for frozen fuse writes
   // One-cycle pulse, one edge after the write
   // Lock byte writes are never reported here
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         writeRefused <= 1'b0;
      end else begin
         writeRefused <= fuseWrite && progLvl_ff && fuseLocked &&
                         fuseSel != FBLP_SEL_LOCK;  // see (R18)
      end
   end

   // Stored bytes read back raw, 0 means programmed
   // Shows the stored copy, not the active one, so
   // a fresh write can be verified before relatch
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fuseRdata <= 8'hFF;
      end else begin
         case (fuseSel)                            // see (R11)
            FBLP_SEL_LOW:  fuseRdata <= lowFuse_ff;
            FBLP_SEL_HIGH: fuseRdata <= highFuse_ff;
            FBLP_SEL_EXT:  fuseRdata <= extFuse_ff;
            default:       fuseRdata <= lock_ff;
         endcase
      end
   end

   // Active copies leave through plain wires
   // so every consumer sees the same latch
   assign activeExt  = extAct_ff;
   assign activeHigh = highAct_ff;
   assign activeLow  = lowAct_ff;
   // Preserve bit bypasses the latch
   // Chip erase in the same session must already
   // honour a preserve bit programmed moments ago
   assign eepromPreserve =
      !highFuse_ff[`FBLP_HI_EEPRES];              // see (R21)
   // Reset vector select, high when programmed
   assign bootResetVector = !extAct_ff[`FBLP_EXT_RSTVEC];

   // Clock output on port B bit zero
   // Enable is low while the pin is driven, which
   // matches a programmed clock-output fuse
   assign portBBitZeroClk = sysClockIn;
   assign portBBitZeroOe  = lowAct_ff[`FBLP_LO_CLOCK_OUTPUT_ENABLE]; // see (R16)

   // Lock pairs as {bit b, bit a}; bit a guards
   // writes, bit b guards reads from the other side
   assign appMode  = {lock_ff[`FBLP_LK_APP_B], lock_ff[`FBLP_LK_APP_A]};
   assign bootMode = {lock_ff[`FBLP_LK_BOOT_B],
                      lock_ff[`FBLP_LK_BOOT_A]};

   // Both classifiers use the latched boot size
   // so the boundary only moves on a relatch
   // Section of the executing address
   fblp_section_classify #(.ADDR_W(ADDR_W)) uExec (
      .addr     (execAddr),
      .bootSize (extAct_ff[`FBLP_EXT_BSZ_HI:`FBLP_EXT_BSZ_LO]),
      .inBoot   (execInBoot)
   );                                              // see (R24)

   // Section of the target address
   fblp_section_classify #(.ADDR_W(ADDR_W)) uTarget (
      .addr     (targetAddr),
      .bootSize (extAct_ff[`FBLP_EXT_BSZ_HI:`FBLP_EXT_BSZ_LO]),
      .inBoot   (targetInBoot)
   );                                              // see (R24)

   // Lock verdict
   // Purely combinational, no state of its own
   // A store is judged as a write even with a load
   fblp_lock_check uCheck (
      .execInBoot   (execInBoot),
      .targetInBoot (targetInBoot),
      .isWrite      (storeReq),
      .appMode      (appMode),
      .bootMode     (bootMode),
      .allow        (allowRaw)
   );

   // Combinational handshake answers
   // Exactly one of the pair is high per request
   // Both low while the core is idle
   // Answer stands as long as the request is held
   assign anyReq      = storeReq || loadReq;
   assign accessAllow = anyReq && allowRaw;
   assign accessDeny  = anyReq && !allowRaw;

   // Interrupt masking across sections
   // Read lock bit b of the section the code runs in
   // decides whether it may take interrupts whose
   // vectors sit in the other section
   always_comb begin
      irqMask = 1'b0;
      if (irqVectorsInBoot && !execInBoot && !appMode[1]) begin
         irqMask = 1'b1;                           // see (R5)
      end
      if (!irqVectorsInBoot && execInBoot && !bootMode[1]) begin
         irqMask = 1'b1;                           // see (R10)
      end
   end
endmodule

// ==== verification/fblp_protect_props.sv ====
`timescale 1ns/1ps
// Port-level checks on the protection block
module fblp_protect_props #(
   parameter int ADDR_W = 13
) (
   input wire logic              clock,
   input wire logic              arst_n,
   input wire logic [ADDR_W-1:0] execAddr,
   input wire logic              storeReq,
   input wire logic              loadReq,
   input wire logic              accessAllow,
   input wire logic              accessDeny,
   input wire logic              irqVectorsInBoot,
   input wire logic              irqMask,
   input wire logic              progMode,
   input wire logic              fuseWrite,
   input wire logic              writeRefused,
   input wire logic [7:0]        activeExt,
   input wire logic [7:0]        activeLow,
   input wire logic              bootResetVector,
   input wire logic              sysClockIn,
   input wire logic              portBBitZeroClk,
   input wire logic              portBBitZeroOe
);
   logic [3:0]  quietCnt; // Cycles since mode level moved
   logic [13:0] bootBase; // First boot word
   logic        execBoot; // Executing inside boot
   assign bootBase = 14'h2000 - (14'h0080 << (2'h3 - activeExt[2:1]));
   assign execBoot = 14'(execAddr) >= bootBase;
   // Quiet-time counter
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         quietCnt <= 4'h0;
      end else if ($changed(progMode)) begin
         quietCnt <= 4'h0;
      end else if (quietCnt != 4'hF) begin
         quietCnt <= quietCnt + 4'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence reqSeen;
      storeReq || loadReq;
   endsequence
   sequence writeThenRefuse;
      fuseWrite ##1 writeRefused;
   endsequence
   a_one_verdict: assert property (
      reqSeen |-> accessAllow ^ accessDeny)
      else $error("access verdict not exclusive");
   a_idle_silent: assert property (
      !(storeReq || loadReq) |-> !accessAllow && !accessDeny)
      else $error("verdict without request");
   a_irq_cross: assert property (
      irqMask |-> execBoot != irqVectorsInBoot)
      else $error("irq masked in vector section");
   a_refuse_cause: assert property (
      writeRefused |-> $past(fuseWrite))
      else $error("refusal without write");
   a_active_quiet: assert property (
      quietCnt > 4'h8 |-> $stable(activeLow) && $stable(activeExt))
      else $error("active fuses moved outside mode change");
   a_ext_unused: assert property (
      activeExt[7:3] == 5'h1F)
      else $error("unused extended bits not one");
   a_vector_sel: assert property (
      bootResetVector == !activeExt[0])
      else $error("reset vector select mismatch");
   a_clk_out: assert property (
      portBBitZeroClk == sysClockIn && portBBitZeroOe == activeLow[6])
      else $error("clock output mismatch");
   c_refuse: cover property (writeThenRefuse);
endmodule
bind fblp_protect fblp_protect_props #(.ADDR_W(ADDR_W)) chk_u (
   .clock(clock), .arst_n(arst_n), .execAddr(execAddr),
   .storeReq(storeReq), .loadReq(loadReq), .accessAllow(accessAllow),
   .accessDeny(accessDeny), .irqVectorsInBoot(irqVectorsInBoot),
   .irqMask(irqMask), .progMode(progMode), .fuseWrite(fuseWrite),
   .writeRefused(writeRefused), .activeExt(activeExt),
   .activeLow(activeLow), .bootResetVector(bootResetVector),
   .sysClockIn(sysClockIn), .portBBitZeroClk(portBBitZeroClk),
   .portBBitZeroOe(portBBitZeroOe));

// ==== verification/fblp_core_model.sv ====
`timescale 1ns/1ps
// Processor core issuing store and load requests
module fblp_core_model #(
   parameter int ADDR_W = 13
) (
   input  wire logic       clock,
   output logic [ADDR_W-1:0] execAddr = '0,
   output logic [ADDR_W-1:0] targetAddr = '0,
   output logic            storeReq = 1'b0,
   output logic            loadReq = 1'b0,
   output logic            vecBoot = 1'b0
);
   // One request held for a cycle, verdict read mid-cycle
   task automatic access(input logic [ADDR_W-1:0] e, t,
                         input logic st, ld, vb);
      @(posedge clock);
      execAddr <= e;
      targetAddr <= t;
      storeReq <= st;
      loadReq <= ld;
      vecBoot <= vb;
      @(negedge clock);
      #1 ;
   endtask
   // Release; stale target address is scrambled, exec address kept
   task automatic idle();
      @(posedge clock);
      storeReq <= 1'b0;
      loadReq <= 1'b0;
      targetAddr <= ~targetAddr;
   endtask
endmodule

// ==== verification/fblp_protect_tb_top.sv ====
`timescale 1ns/1ps
module fblp_protect_tb_top;
   import fblp_pkg::*;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [12:0] execAddr, targetAddr;
   logic        storeReq, loadReq, vecBoot, accessAllow, accessDeny;
   logic        irqMask, eePres, bootVec, pbClk, pbOe, writeRefused;
   logic        progMode = 1'b0, serialPath = 1'b0, fuseWrite = 1'b0;
   logic        chipErase = 1'b0, sysClk = 1'b0, refSeen = 1'b0;
   fblp_sel_e   fuseSel = FBLP_SEL_LOW;
   logic [7:0]  fuseWdata = 8'hFF, fuseRdata, actExt, actHigh, actLow;
   logic [1:0]  modes[4] = '{2'b11, 2'b10, 2'b00, 2'b01};
   logic [1:0]  m;
   int          bad_count = 0;
   int          samples_checked = 0;
   localparam logic [12:0] APP = 13'h0100, BOOT = 13'h1E00;
   localparam logic [12:0] APP1 = 13'h0101, BOOT1 = 13'h1E01;
   localparam logic [12:0] TOP = 13'h1F80;
   localparam logic        ON = 1'b1, OFF = 1'b0;
   always #2.5 clock = ~clock;
   // Forwarded clock source and refusal catcher
   always @(posedge clock) sysClk <= ~sysClk;
   always @(posedge clock) if (writeRefused === 1'b1) refSeen <= 1'b1;
   fblp_core_model core_u (.clock(clock), .execAddr(execAddr),
      .targetAddr(targetAddr), .storeReq(storeReq), .loadReq(loadReq),
      .vecBoot(vecBoot));
   fblp_protect dut_u (.clock(clock), .arst_n(arst_n),
      .execAddr(execAddr), .targetAddr(targetAddr), .storeReq(storeReq),
      .loadReq(loadReq), .accessAllow(accessAllow),
      .accessDeny(accessDeny), .irqVectorsInBoot(vecBoot),
      .irqMask(irqMask), .progMode(progMode), .serialPath(serialPath),
      .fuseWrite(fuseWrite), .fuseSel(fuseSel), .fuseWdata(fuseWdata),
      .chipErase(chipErase), .fuseRdata(fuseRdata),
      .writeRefused(writeRefused), .activeExt(actExt),
      .activeHigh(actHigh), .activeLow(actLow), .eepromPreserve(eePres),
      .bootResetVector(bootVec), .sysClockIn(sysClk),
      .portBBitZeroClk(pbClk), .portBBitZeroOe(pbOe));
   task automatic chk(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input fblp_sel_e s, input logic [7:0] d,
                     input logic ser);
      @(posedge clock);
      fuseSel <= s;
      fuseWdata <= d;
      serialPath <= ser;
      fuseWrite <= 1'b1;
      @(posedge clock);
      fuseWrite <= 1'b0;
   endtask
   task automatic rd(input fblp_sel_e s, input logic [7:0] exp);
      @(posedge clock);
      fuseSel <= s;
      repeat (2) @(posedge clock);
      #1 chk(fuseRdata, exp);
   endtask
   task automatic acc(input logic [12:0] e, t, input logic st, vb, a, k);
      core_u.access(e, t, st, !st, vb);
      chk({7'h0, accessAllow}, {7'h0, a});
      chk({7'h0, accessDeny}, {7'h0, !a});
      chk({7'h0, irqMask}, {7'h0, k});
      core_u.idle();
   endtask
   task automatic setProg(input logic lvl);
      @(posedge clock);
      progMode <= lvl;
      repeat (8) @(posedge clock);
      #1 ;
   endtask
   // Hang guard
   initial begin
      repeat (5000) @(posedge clock);
      bad_count++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(actExt, 8'hF9);
      chk(actHigh, 8'hDF);
      chk(actLow, 8'h62);
      chk({7'h0, pbOe}, 8'h01);
      chk({7'h0, eePres}, 8'h00);
      rd(FBLP_SEL_LOW, 8'h62);
      setProg(ON);
      // Fuses first, lock bits afterwards
      wr(FBLP_SEL_LOW, 8'hA2, OFF);
      rd(FBLP_SEL_LOW, 8'hA2);
      chk(actLow, 8'h62);
      wr(FBLP_SEL_HIGH, 8'hD7, OFF);
      #1 chk({7'h0, eePres}, 8'h01);
      chk(actHigh, 8'hDF);
      wr(FBLP_SEL_HIGH, 8'hFF, ON);
      rd(FBLP_SEL_HIGH, 8'hDF);
      wr(FBLP_SEL_EXT, 8'h00, OFF);
      rd(FBLP_SEL_EXT, 8'hF8);
      // Every lock mode on both pairs
      for (int i = 0; i < 4; i++) begin
         m = modes[i];
         if (i == 3) begin
            @(posedge clock);
            chipErase <= 1'b1;
            @(posedge clock);
            chipErase <= 1'b0;
            rd(FBLP_SEL_LOCK, 8'hFF);
            rd(FBLP_SEL_LOW, 8'hA2);
         end
         wr(FBLP_SEL_LOCK, {2'b11, m, m, 2'b11}, OFF);
         acc(APP, APP1, ON, ON, m[0], !m[1]);
         acc(BOOT, BOOT1, ON, OFF, m[0], !m[1]);
         acc(BOOT, APP, OFF, ON, m[1], OFF);
         acc(APP, BOOT, OFF, OFF, m[1], OFF);
      end
      setProg(OFF);
      chk(actLow, 8'hA2);
      chk({7'h0, pbOe}, 8'h00);
      chk(actExt, 8'hF8);
      chk({7'h0, bootVec}, 8'h01);
      // Smallest boot size moves the boundary to the top
      setProg(ON);
      wr(FBLP_SEL_EXT, 8'h06, OFF);
      #1 chk(actExt, 8'hF8);
      setProg(OFF);
      chk(actExt, 8'hFE);
      acc(BOOT, TOP, OFF, OFF, OFF, OFF);
      acc(TOP, BOOT, OFF, ON, OFF, OFF);
      chk({7'h0, refSeen}, 8'h00);
      setProg(ON);
      wr(FBLP_SEL_LOCK, 8'hFE, OFF);
      wr(FBLP_SEL_LOW, 8'hFF, OFF);
      rd(FBLP_SEL_LOW, 8'hA2);
      chk({7'h0, refSeen}, 8'h01);
      close_out();
   end
endmodule
